// ==== elsl_defines.vh ====
// constants for the little-endian external memory lane steering block
// Behaviour
// - half-word address: low or upper half
// - 32-bit half write: replicate, strobes UUAA/AAUU
// - 16-bit half access: one transfer, XXAA
// - 8-bit half write: two XXXA writes, low first
// - 32-bit half read: pick half into bits 15..0
// - 8-bit half read: two XXXA reads, low first
// - byte address classed by lane and parity
// - 32-bit byte write: replicate, one-hot lane strobe
// - 16-bit byte: even address, XXUA or XXAU
// - 8-bit byte: single XXXA transfer at address
// - byte read: selected lane into bits 7..0
// - A asserted, U deasserted, lane 3 leftmost
// - mapping only when little-endian strap sampled
`ifndef ELSL_DEFINES_VH
`define ELSL_DEFINES_VH

// bank width codes, same coding as the boot width straps
`define ELSL_WIDTH_8 2'h0
`define ELSL_WIDTH_16 2'h1
`define ELSL_WIDTH_32 2'h2
`define ELSL_WIDTH_RSVD 2'h3

// active-lane patterns, bit 3 is the leftmost letter
`define ELSL_LANES_NONE 4'h0
`define ELSL_LANES_LOW_HALF 4'h3
`define ELSL_LANES_UP_HALF 4'hC
`define ELSL_LANES_LANE0 4'h1
`define ELSL_LANES_LANE1 4'h2

// all lanes idle on the active-low strobes and masks
`define ELSL_LANES_IDLE_N 4'hF

// strap level meaning little-endian external format
`define ELSL_ENDIAN_LITTLE 1'b1

// address alignment masks
`define ELSL_WORD_ALIGN 32'hFFFFFFFC
`define ELSL_HALF_ALIGN 32'hFFFFFFFE

`endif

// ==== elsl_lane_map.v ====
// address, lane and write-data mapping for one external transfer
`include "elsl_defines.vh"

module elsl_lane_map (
   input wire [31:0] addr_i,
   input wire half_i,
   input wire [1:0] width_i,
   input wire beat_i,
   input wire [15:0] wdata_i,
   output reg [31:0] ext_addr_o,
   output reg [3:0] lanes_o,
   output reg [31:0] wdata_o
);

   // lanes_o is active high here; the top inverts it for the pins
   always @* begin
      ext_addr_o = addr_i;
      lanes_o = `ELSL_LANES_LANE0;
      wdata_o = {16'h0000, wdata_i};
      case (width_i)
         `ELSL_WIDTH_32: begin
            ext_addr_o = addr_i & `ELSL_WORD_ALIGN;
            if (half_i) begin
               // bit 1 picks lower or upper half
               lanes_o = addr_i[1] ? `ELSL_LANES_UP_HALF : `ELSL_LANES_LOW_HALF;
               wdata_o = {wdata_i, wdata_i};
            end else begin
               lanes_o = 4'h1 << addr_i[1:0];
               wdata_o = {4{wdata_i[7:0]}};
            end
         end
         `ELSL_WIDTH_16: begin
            ext_addr_o = addr_i & `ELSL_HALF_ALIGN;
            if (half_i) begin
               lanes_o = `ELSL_LANES_LOW_HALF;
            end else begin
               // x lanes of the pattern are driven inactive
               lanes_o = addr_i[0] ? `ELSL_LANES_LANE1 : `ELSL_LANES_LANE0;
               wdata_o = {16'h0000, wdata_i[7:0], wdata_i[7:0]};
            end
         end
         default: begin
            // 8-bit bank: second beat of a half-word is address plus one
            if (half_i) begin
               ext_addr_o = addr_i + {31'h00000000, beat_i};
               wdata_o = {24'h000000, beat_i ? wdata_i[15:8] : wdata_i[7:0]};
            end else begin
               wdata_o = {24'h000000, wdata_i[7:0]};
            end
            lanes_o = `ELSL_LANES_LANE0;
         end
      endcase
   end

endmodule // elsl_lane_map

// ==== elsl_mem_model.sv ====
// behavioural external memory bank answering the steering block
module elsl_mem_model (
   input wire core_clk_i,
   input wire nrst_i,
   input wire mem_req_i,
   input wire mem_write_i,
   input wire [31:0] addr_i,
   input wire [3:0] strobe_n_i,
   input wire [3:0] mask_n_i,
   input wire [31:0] wdata_i,
   input wire oe_n_i,
   input wire [1:0] delay_i,
   output logic ack_o,
   output logic [31:0] rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:1023];
   logic [1:0] cnt_ff;
   integer k;
   // ack after delay_i waits; pins toggle outside the ack cycle so stale data never passes
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_o <= 1'b0;
         cnt_ff <= 2'h0;
         rdata_o <= 32'h0;
      end else begin
         ack_o <= 1'b0;
         rdata_o <= ~rdata_o;
         if (mem_req_i && !ack_o) begin
            if (cnt_ff == delay_i) begin
               ack_o <= 1'b1;
               cnt_ff <= 2'h0;
               for (k = 0; k < 4; k++) begin
                  if (mem_write_i && !oe_n_i && !strobe_n_i[k])
                     mem[addr_i[9:0] + k] <= wdata_i[8*k +: 8];
                  rdata_o[8*k +: 8] <= mask_n_i[k] ? ~mem[addr_i[9:0] + k] : mem[addr_i[9:0] + k];
               end
            end else begin
               cnt_ff <= cnt_ff + 2'h1;
            end
         end
      end
   end
endmodule // elsl_mem_model

// ==== elsl_read_align.v ====
// picks the addressed lane or half out of the external read data
`include "elsl_defines.vh"

module elsl_read_align (
   input wire [31:0] rdata_i,
   input wire [1:0] addr_lo_i,
   input wire half_i,
   input wire [1:0] width_i,
   output reg [15:0] value_o
);

   // result always lands at bit 0; upper bits zero for bytes
   always @* begin
      value_o = {8'h00, rdata_i[7:0]};
      case (width_i)
         `ELSL_WIDTH_32: begin
            if (half_i) begin
               value_o = addr_lo_i[1] ? rdata_i[31:16] : rdata_i[15:0];
            end else begin
               case (addr_lo_i)
                  2'h0: value_o = {8'h00, rdata_i[7:0]};
                  2'h1: value_o = {8'h00, rdata_i[15:8]};
                  2'h2: value_o = {8'h00, rdata_i[23:16]};
                  default: value_o = {8'h00, rdata_i[31:24]};
               endcase
            end
         end
         `ELSL_WIDTH_16: begin
            if (half_i) begin
               value_o = rdata_i[15:0];
            end else begin
               value_o = {8'h00, addr_lo_i[0] ? rdata_i[15:8] : rdata_i[7:0]};
            end
         end
         default: begin
            // 8-bit bank: only bits 7..0 carry data
            value_o = {8'h00, rdata_i[7:0]};
         end
      endcase
   end

endmodule // elsl_read_align

// ==== elsl_steer.v ====
// top of the little-endian external memory lane steering block
`include "elsl_defines.vh"

module elsl_steer #(
   // bank count and the width of the bank index
   parameter NUM_BANKS = 4,
   parameter BANK_IW = 2
) (
   // clock, reset and power-on strap
   input wire core_clk_i,
   input wire nrst_i,
   input wire endian_strap_i,
   // per-bank width codes, two bits a bank
   input wire [2*NUM_BANKS-1:0] bank_width_cfg_i,
   // system-side request
   input wire req_valid_i,
   input wire req_write_i,
   input wire req_half_i,
   input wire [BANK_IW-1:0] req_bank_i,
   input wire [31:0] internal_system_address_i,
   input wire [15:0] internal_system_data_i,
   // system-side response
   output wire req_ready_o,
   output wire resp_valid_o,
   output wire resp_err_o,
   output wire [15:0] resp_rdata_o,
   // external transfer handshake
   output wire mem_req_o,
   output wire mem_write_o,
   input wire mem_ack_i,
   // external address, lanes and data pins
   output wire [31:0] external_address_pins_o,
   output wire [3:0] write_lane_strobe_n_o,
   output wire [3:0] sdram_lane_mask_o,
   output wire [31:0] external_data_pins_o,
   output wire external_data_pins_oe_n_o,
   input wire [31:0] external_data_pins_i
);

   // sequencer states
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_PREP = 2'h1;
   localparam [1:0] ST_BUS = 2'h2;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;

   // endian strap capture
   reg strap_taken_ff;
   reg little_ff;

   // latched request
   reg write_ff;
   reg half_ff;
   reg [1:0] width_ff;
   reg [31:0] addr_ff;
   reg [15:0] wdata_ff;
   reg beat_ff;
   reg [7:0] low_byte_ff;
   reg [1:0] nxt_width;

   // registered outputs
   reg ready_ff;
   reg resp_valid_ff;
   reg resp_err_ff;
   reg [15:0] resp_rdata_ff;
   reg mem_req_ff;
   reg mem_write_ff;
   reg [31:0] ext_addr_ff;
   reg [3:0] strobe_n_ff;
   reg [3:0] mask_ff;
   reg [31:0] ext_wdata_ff;
   reg oe_n_ff;

   // next values
   reg nxt_ready;
   reg nxt_resp_valid;
   reg nxt_resp_err;
   reg [15:0] nxt_resp_rdata;
   reg nxt_mem_req;
   reg nxt_mem_write;
   reg [31:0] nxt_ext_addr;
   reg [3:0] nxt_strobe_n;
   reg [3:0] nxt_mask;
   reg [31:0] nxt_ext_wdata;
   reg nxt_oe_n;
   reg nxt_beat;
   reg [7:0] nxt_low_byte;

   wire [31:0] map_addr;
   wire [3:0] map_lanes;
   wire [31:0] map_wdata;
   wire [15:0] rd_value;
   wire take;
   wire split;
   wire bad_req;
   wire bad_endian;
   wire bad_width;
   wire bad_align;

   assign take = req_valid_i & ready_ff;

   // an 8-bit bank turns a half-word into two transfers
   assign split = half_ff & (width_ff == `ELSL_WIDTH_8);

   // big-endian mapping lives elsewhere, so every request is refused then
   assign bad_endian = (little_ff != `ELSL_ENDIAN_LITTLE);
   // reserved width code has no lane table
   assign bad_width = (width_ff == `ELSL_WIDTH_RSVD);
   // a half-word on an odd address would straddle two halves
   assign bad_align = half_ff & addr_ff[0];
   // refused requests never reach the pins
   assign bad_req = bad_endian | bad_width | bad_align;

   // width of the addressed bank, taken when the request is accepted
   always @* begin
      nxt_width = bank_width_cfg_i[1:0];
      if (req_bank_i < NUM_BANKS) begin
         nxt_width = bank_width_cfg_i[2*req_bank_i +: 2];
      end
   end

   elsl_lane_map u_lane_map (
      .addr_i(addr_ff),
      .half_i(half_ff),
      .width_i(width_ff),
      .beat_i(beat_ff),
      .wdata_i(wdata_ff),
      .ext_addr_o(map_addr),
      .lanes_o(map_lanes),
      .wdata_o(map_wdata)
   );

   elsl_read_align u_read_align (
      .rdata_i(external_data_pins_i),
      .addr_lo_i(addr_ff[1:0]),
      .half_i(half_ff),
      .width_i(width_ff),
      .value_o(rd_value)
   );

   // strap is caught by a clocked process on the first edge after release
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         strap_taken_ff <= 1'b0;
         little_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         // later strap changes are ignored until the next reset
         strap_taken_ff <= 1'b1;
         little_ff <= endian_strap_i;
      end
   end

   // request latch; fields hold until the sequence ends
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         write_ff <= 1'b0;
         half_ff <= 1'b0;
         width_ff <= `ELSL_WIDTH_8;
         addr_ff <= 32'h00000000;
         wdata_ff <= 16'h0000;
      end else if (take) begin
         // width frozen per request; a config change mid-sequence is harmless
         write_ff <= req_write_i;
         half_ff <= req_half_i;
         width_ff <= nxt_width;
         addr_ff <= internal_system_address_i;
         wdata_ff <= internal_system_data_i;
      end
   end

   // sequencer: prepare, hold the bus until ack, repeat for a split
   always @* begin
      nxt_state = state_ff;
      nxt_ready = ready_ff;
      nxt_resp_valid = 1'b0;
      nxt_resp_err = 1'b0;
      nxt_resp_rdata = resp_rdata_ff;
      nxt_mem_req = mem_req_ff;
      nxt_mem_write = mem_write_ff;
      nxt_ext_addr = ext_addr_ff;
      nxt_strobe_n = strobe_n_ff;
      nxt_mask = mask_ff;
      nxt_ext_wdata = ext_wdata_ff;
      nxt_oe_n = oe_n_ff;
      nxt_beat = beat_ff;
      nxt_low_byte = low_byte_ff;
      case (state_ff)
         ST_IDLE: begin
            // ready only once the strap has been sampled
            nxt_ready = strap_taken_ff;
            if (take) begin
               nxt_ready = 1'b0;
               nxt_beat = 1'b0;
               nxt_state = ST_PREP;
            end
         end
         // drive one transfer, or refuse without touching the pins
         ST_PREP: begin
            if (bad_req) begin
               // no external cycle at all for a refused request
               nxt_resp_valid = 1'b1;
               nxt_resp_err = 1'b1;
               nxt_resp_rdata = 16'h0000;
               nxt_ready = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               // load the mapped transfer into the pin flops
               nxt_mem_req = 1'b1;
               nxt_mem_write = write_ff;
               nxt_ext_addr = map_addr;
               // pins are active low: A is 0, U and X are 1
               nxt_mask = ~map_lanes;
               nxt_strobe_n = write_ff ? ~map_lanes : `ELSL_LANES_IDLE_N;
               nxt_ext_wdata = map_wdata;
               nxt_oe_n = ~write_ff;
               nxt_state = ST_BUS;
            end
         end
         // hold everything until the memory acknowledges
         ST_BUS: begin
            if (mem_ack_i) begin
               nxt_mem_req = 1'b0;
               nxt_mem_write = 1'b0;
               nxt_strobe_n = `ELSL_LANES_IDLE_N;
               nxt_mask = `ELSL_LANES_IDLE_N;
               nxt_oe_n = 1'b1;
               if (split && !beat_ff) begin
                  // first beat carries the low byte
                  nxt_low_byte = external_data_pins_i[7:0];
                  nxt_beat = 1'b1;
                  nxt_state = ST_PREP;
               end else begin
                  // last beat: answer and free the request side
                  nxt_resp_valid = 1'b1;
                  nxt_ready = 1'b1;
                  nxt_state = ST_IDLE;
                  if (write_ff) begin
                     nxt_resp_rdata = 16'h0000;
                  end else if (split) begin
                     nxt_resp_rdata = {external_data_pins_i[7:0], low_byte_ff};
                  end else begin
                     nxt_resp_rdata = rd_value;
                  end
               end
            end
         end
         // unused code: fall back to idle
         default: begin
            nxt_state = ST_IDLE;
            nxt_ready = 1'b0;
            nxt_mem_req = 1'b0;
         end
      endcase
   end

   // all outputs come straight from these flops
   always @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_ff <= ST_IDLE;
         ready_ff <= 1'b0;
         resp_valid_ff <= 1'b0;
         resp_err_ff <= 1'b0;
         resp_rdata_ff <= 16'h0000;
         mem_req_ff <= 1'b0;
         mem_write_ff <= 1'b0;
         ext_addr_ff <= 32'h00000000;
         strobe_n_ff <= `ELSL_LANES_IDLE_N;
         mask_ff <= `ELSL_LANES_IDLE_N;
         ext_wdata_ff <= 32'h00000000;
         oe_n_ff <= 1'b1;
         beat_ff <= 1'b0;
         low_byte_ff <= 8'h00;
      end else begin
         state_ff <= nxt_state;
         ready_ff <= nxt_ready;
         resp_valid_ff <= nxt_resp_valid;
         resp_err_ff <= nxt_resp_err;
         resp_rdata_ff <= nxt_resp_rdata;
         mem_req_ff <= nxt_mem_req;
         mem_write_ff <= nxt_mem_write;
         ext_addr_ff <= nxt_ext_addr;
         strobe_n_ff <= nxt_strobe_n;
         mask_ff <= nxt_mask;
         ext_wdata_ff <= nxt_ext_wdata;
         oe_n_ff <= nxt_oe_n;
         beat_ff <= nxt_beat;
         low_byte_ff <= nxt_low_byte;
      end
   end

   // ports are plain copies of the output flops
   assign req_ready_o = ready_ff;
   assign resp_valid_o = resp_valid_ff;
   assign resp_err_o = resp_err_ff;
   assign resp_rdata_o = resp_rdata_ff;
   assign mem_req_o = mem_req_ff;
   assign mem_write_o = mem_write_ff;
   assign external_address_pins_o = ext_addr_ff;
   assign write_lane_strobe_n_o = strobe_n_ff;
   assign sdram_lane_mask_o = mask_ff;
   assign external_data_pins_o = ext_wdata_ff;
   assign external_data_pins_oe_n_o = oe_n_ff;

endmodule // elsl_steer

// ==== elsl_steer_bench.sv ====
// self-checking bench for the lane steering block
module elsl_steer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 0, nrst_i = 0, endian_strap_i = 1;
   logic req_valid_i = 0, req_write_i = 0, req_half_i = 0;
   logic [1:0] req_bank_i = 0, dly = 0;
   logic [31:0] internal_system_address_i = 0;
   logic [15:0] internal_system_data_i = 0;
   logic [7:0] bank_width_cfg_i = 8'hC6; // bank3 reserved, 8, 16, 32 bit
   wire req_ready_o, resp_valid_o, resp_err_o, mem_req_o, mem_write_o, mem_ack_i;
   wire external_data_pins_oe_n_o;
   wire [15:0] resp_rdata_o;
   wire [31:0] external_address_pins_o, external_data_pins_o, external_data_pins_i;
   wire [3:0] write_lane_strobe_n_o, sdram_lane_mask_o;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   logic er;
   logic [15:0] rd;

   always #5 core_clk_i = ~core_clk_i;

   elsl_steer dut (.*);
   elsl_mem_model u_mem (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mem_req_i(mem_req_o),
      .mem_write_i(mem_write_o), .addr_i(external_address_pins_o),
      .strobe_n_i(write_lane_strobe_n_o), .mask_n_i(sdram_lane_mask_o),
      .wdata_i(external_data_pins_o), .oe_n_i(external_data_pins_oe_n_o), .delay_i(dly),
      .ack_o(mem_ack_i), .rdata_o(external_data_pins_i));

   function automatic logic [7:0] fill(int a);
      return a[7:0] ^ 8'h5A;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      if (error_cnt == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_of_test;
      end
   end

   task automatic rst(input logic strap);
      nrst_i <= 1'b0;
      endian_strap_i <= strap;
      repeat (6) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
   endtask

   // one request held until taken, then the response judged on its error flag
   task automatic req(input logic w, h, input logic [1:0] b, input int a, input logic [15:0] d,
      input logic ee);
      req_valid_i <= 1'b1;
      req_write_i <= w;
      req_half_i <= h;
      req_bank_i <= b;
      internal_system_address_i <= a;
      internal_system_data_i <= d;
      do @(posedge core_clk_i); while (req_ready_o !== 1'b1);
      req_valid_i <= 1'b0;
      do @(posedge core_clk_i); while (resp_valid_o !== 1'b1);
      er = resp_err_o;
      rd = resp_rdata_o;
      chk(er, ee);
   endtask

   // half-word write then read in every bank width, both halves
   task automatic t_half;
      int a;
      for (int b = 0; b < 3; b++) begin
         for (int o = 0; o < 4; o += 2) begin
            a = 'h100 + b * 'h10 + o;
            req(1, 1, b, a, 16'hC000 + a, 0);
            chk(u_mem.mem[a], a[7:0]);
            chk(u_mem.mem[a + 1], 8'hC0 + a[15:8]);
            chk(u_mem.mem[a + 2], fill(a + 2));
            req(0, 1, b, a, 0, 0);
            chk(rd, 16'hC000 + a);
         end
      end
   endtask

   // byte write on every lane of every width, the next byte untouched, then read back
   task automatic t_byte;
      int a;
      for (int b = 0; b < 3; b++) begin
         for (int l = 0; l < 4; l++) begin
            a = 'h300 + b * 'h10 + l;
            req(1, 0, b, a, 16'hEE30 + l, 0);
            chk(u_mem.mem[a], 8'h30 + l);
            chk(u_mem.mem[a + 1], fill(a + 1));
         end
         for (int l = 0; l < 4; l++) begin
            req(0, 0, b, 'h300 + b * 'h10 + l, 0, 0);
            chk(rd, 16'h0030 + l);
         end
      end
   endtask

   // refused requests flag an error; the big-endian write leaves memory alone
   task automatic t_refuse;
      req(1, 1, 0, 'h401, 16'h1234, 1);
      chk(rd, 16'h0);
      req(0, 0, 3, 'h400, 0, 1);
      rst(0);
      req(1, 0, 0, 'h410, 16'h0077, 1);
      chk(u_mem.mem['h410], fill('h410));
      rst(1);
      req(1, 0, 2, 'h410, 16'h0077, 0);
      chk(u_mem.mem['h410], 8'h77);
   endtask

   initial begin
      for (int i = 0; i < 1024; i++) u_mem.mem[i] = fill(i);
      rst(1);
      t_half;
      dly <= 2'h3; // slow memory for the byte pass
      t_byte;
      t_refuse;
      end_of_test;
   end
endmodule // elsl_steer_bench

// ==== elsl_steer_properties.sv ====
// port assertions for the lane steering block
module elsl_steer_properties (
   input wire core_clk_i,
   input wire nrst_i,
   input wire req_valid_i,
   input wire req_half_i,
   input wire [31:0] internal_system_address_i,
   input wire req_ready_o,
   input wire resp_valid_o,
   input wire resp_err_o,
   input wire mem_req_o,
   input wire mem_write_o,
   input wire mem_ack_i,
   input wire [31:0] external_address_pins_o,
   input wire [3:0] write_lane_strobe_n_o,
   input wire [3:0] sdram_lane_mask_o,
   input wire external_data_pins_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // accepted request
   wire take = req_valid_i && req_ready_o;
   wire [3:0] msk = sdram_lane_mask_o;
   wire [1:0] alo = external_address_pins_o[1:0];
   property p_idle; !mem_req_o |-> write_lane_strobe_n_o == 4'hF && msk == 4'hF; endproperty
   a_idle: assert property (p_idle) else $error("lanes active while idle");
   property p_rd; mem_req_o && !mem_write_o |-> write_lane_strobe_n_o == 4'hF && external_data_pins_oe_n_o; endproperty
   a_rd: assert property (p_rd) else $error("write strobe on read");
   property p_wr; mem_req_o && mem_write_o |-> write_lane_strobe_n_o == msk && !external_data_pins_oe_n_o; endproperty
   a_wr: assert property (p_wr) else $error("strobe and mask differ");
   property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(external_address_pins_o) && $stable(msk); endproperty
   a_hold: assert property (p_hold) else $error("transfer changed before ack");
   property p_pat; mem_req_o |-> msk inside {4'hE, 4'hD, 4'hB, 4'h7, 4'h3, 4'hC}; endproperty
   a_pat: assert property (p_pat) else $error("illegal lane pattern");
   property p_upper; mem_req_o && msk == 4'h3 |-> alo == 2'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper half not at lower address");
   property p_lower; mem_req_o && msk == 4'hC |-> !alo[0]; endproperty
   a_lower: assert property (p_lower) else $error("half transfer misaligned");
   property p_lane; mem_req_o && (msk == 4'hB || msk == 4'h7) |-> alo == 2'h0; endproperty
   a_lane: assert property (p_lane) else $error("byte lane not word aligned");
   property p_mis; take && req_half_i && internal_system_address_i[0] |-> ##2 resp_valid_o && resp_err_o; endproperty
   a_mis: assert property (p_mis) else $error("odd half not refused");
   property p_resp; take |=> !req_ready_o ##[1:40] resp_valid_o; endproperty
   a_resp: assert property (p_resp) else $error("no response in time");
   c_split: cover property (mem_req_o && mem_write_o && msk == 4'hE);
   c_err: cover property (resp_valid_o && resp_err_o);
   c_upper: cover property (mem_req_o && !mem_write_o && msk == 4'h3);
endmodule // elsl_steer_properties

bind elsl_steer elsl_steer_properties u_props (.*);
